// file: hdl/servo_guard_params.svh
/*
  Offsets, field positions, reset values and timing counts of the
  collision detection and automatic servo-off block.
  Assumes a 50 MHz clock and a 32-bit plain register port.
*/
`ifndef SERVO_GUARD_PARAMS_SVH
`define SERVO_GUARD_PARAMS_SVH

`define CLK_HZ          50000000
`define TICK_MS_TIME    1
`define TICK_MS_CYCLES  ((`CLK_HZ / 1000) * `TICK_MS_TIME)
`define MS_PER_S        1000

`define OFS_CFG         8'h00
`define OFS_JUDGE_MS    8'h04
`define OFS_DELAY1      8'h08
`define OFS_DELAY2      8'h0c
`define OFS_DELAY3      8'h10
`define OFS_STATE       8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1c
`define OFS_CMD         8'h20
`define OFS_TABLE       8'h40
`define TABLE_WORDS     16

`define CFG_SEL_LSB     0
`define CFG_GMODE_LSB   4
`define CFG_CMODE_BIT   8
`define TBL_MODE_LSB    16

`define RST_CFG         32'h00000000
`define RST_JUDGE_MS    14'd255
`define JUDGE_MS_MAX    14'd9999
`define THRESH_MAX      7'd100
`define RST_DELAY       16'h0000

`define IRQ_COLLISION   0
`define IRQ_SERVO_OFF   1
`define IRQ_DONE        2
`define IRQ_BITS        3

`endif

// file: hdl/servo_guard_pkg.sv
/*
  Types of the collision detection and automatic servo-off block.
  Assumes nothing of its surroundings.
*/
package servo_guard_pkg;

  localparam int POS_COUNT = 8;

  typedef logic [2:0] pos_no_t;

  typedef enum logic [1:0] {
    STOP_KEEP_ON,
    STOP_DELAY1,
    STOP_DELAY2,
    STOP_DELAY3
  } stop_mode_e;

  typedef enum {
    SV_IDLE,
    SV_MOVING,
    SV_WAIT_OFF,
    SV_AUTO_OFF,
    SV_FAULT
  } servo_state_e;

  typedef struct packed {
    logic        move_start;
    pos_no_t     target_no;
    logic        from_table;
    logic        pressing;
    logic        pause_release;
    logic        move_done;
    logic        press_contact;
    logic        in_position;
    logic [6:0]  cmd_current_pct;
    logic [15:0] current_pos;
  } motion_in_s;

  typedef struct packed {
    stop_mode_e  stop_mode;
    logic [6:0]  threshold;
    logic [15:0] zone_hi;
    logic [15:0] zone_lo;
  } pos_entry_s;

endpackage

// file: hdl/tick_divider.sv
/*
  Divides the core clock into one-cycle millisecond and second enables.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`include "servo_guard_params.svh"

module tick_divider #(
  parameter int MS_CYCLES = `TICK_MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick_ms,
  output logic      tick_s
);

  logic [31:0] cyc_reg;
  logic [9:0]  ms_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 32'h0;
      tick_ms <= 1'b0;
    end else if (cyc_reg == 32'(MS_CYCLES - 1)) begin
      cyc_reg <= 32'h0;
      tick_ms <= 1'b1;
    end else begin
      cyc_reg <= cyc_reg + 32'h1;
      tick_ms <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_reg <= 10'h0;
      tick_s <= 1'b0;
    end else begin
      tick_s <= 1'b0;
      if (tick_ms) begin
        if (ms_reg == 10'(`MS_PER_S - 1)) begin
          ms_reg <= 10'h0;
          tick_s <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 10'h1;
        end
      end
    end
  end

endmodule

// file: hdl/servo_guard.sv
/*
  Collision detection and automatic servo-off supervisor with its
  register port, position table and interrupt logic.
  Assumes motion inputs synchronous to clk and a master that never
  asserts both strobes at once.
*/
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "servo_guard_params.svh"

module servo_guard
  import servo_guard_pkg::*;
#(
  parameter int MS_CYCLES = `TICK_MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire motion_in_s  motion,
  output logic             servo_on,
  output logic             load_judge,
  output logic             alarm_cancel,
  output logic             alarm_message,
  output logic             positioning_complete,
  output pos_no_t          completed_position_number,
  output logic [POS_COUNT-1:0] per_position_done_flag,
  output logic             led_steady_green,
  output logic             irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  function automatic logic in_zone(input logic [15:0] p,
                                   input pos_entry_s  e);
    in_zone = (p >= e.zone_lo) && (p <= e.zone_hi);
  endfunction

  logic        tick_ms;
  logic        tick_s;
  logic [2:0]  sel_reg;
  stop_mode_e  gmode_reg;
  logic        cmode_reg;
  logic [13:0] judge_ms_reg;
  logic [15:0] delay_reg [3];
  logic [31:0] table_reg [`TABLE_WORDS];
  logic [`IRQ_BITS-1:0] irq_stat_reg;
  logic [`IRQ_BITS-1:0] irq_mask_reg;
  logic        alarm_clear;
  servo_state_e state_reg;
  servo_state_e state_next;
  pos_no_t     cur_no_reg;
  logic        positioned_reg;
  logic        table_move_reg;
  logic        pressing_reg;
  logic        suppress_reg;
  logic        after_pause_reg;
  logic        done_reg;
  logic [13:0] dwell_reg;
  logic [15:0] sec_reg;
  logic [15:0] delay_sel;
  stop_mode_e  mode_sel;
  pos_entry_s  entry;
  logic        detect_en;
  logic        exempt_sel;
  logic        over;
  logic        collision;
  logic        arm;
  logic        expire;

  tick_divider #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick_ms (tick_ms),
    .tick_s  (tick_s)
  );

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg      <= 3'h0;
      gmode_reg    <= STOP_KEEP_ON;
      cmode_reg    <= 1'b0;
      judge_ms_reg <= `RST_JUDGE_MS;
      irq_mask_reg <= '0;
    end else if (reg_wr) begin
      if (hit(reg_addr, `OFS_CFG)) begin
        sel_reg   <= reg_wdata[`CFG_SEL_LSB +: 3];
        gmode_reg <= stop_mode_e'(reg_wdata[`CFG_GMODE_LSB +: 2]);
        cmode_reg <= reg_wdata[`CFG_CMODE_BIT];
      end
      if (hit(reg_addr, `OFS_JUDGE_MS)) begin
        // Out-of-range values in bits 13:0 saturate; the upper bits are ignored
        if (reg_wdata[13:0] > `JUDGE_MS_MAX) begin
          judge_ms_reg <= `JUDGE_MS_MAX;
        end else begin
          judge_ms_reg <= reg_wdata[13:0];
        end
      end
      if (hit(reg_addr, `OFS_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata[`IRQ_BITS-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_delay
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          delay_reg[gi] <= `RST_DELAY;
        end else if (reg_wr &&
                     hit(reg_addr, 8'(`OFS_DELAY1 + 4 * gi))) begin
          delay_reg[gi] <= reg_wdata[15:0];
        end
      end
    end
    for (gi = 0; gi < `TABLE_WORDS; gi++) begin : g_table
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          table_reg[gi] <= 32'h0;
        end else if (reg_wr &&
                     hit(reg_addr, 8'(`OFS_TABLE + 4 * gi))) begin
          table_reg[gi] <= reg_wdata;
        end
      end
    end
    for (gi = 0; gi < POS_COUNT; gi++) begin : g_flag
      assign per_position_done_flag[gi] =
        positioning_complete && (completed_position_number == pos_no_t'(gi));
    end
  endgenerate

  assign alarm_clear = reg_wr && hit(reg_addr, `OFS_CMD) && reg_wdata[0];

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0;
      if (hit(reg_addr, `OFS_CFG)) begin
        reg_rdata <= {23'h0, cmode_reg, 2'h0, gmode_reg, 1'b0, sel_reg};
      end
      if (hit(reg_addr, `OFS_JUDGE_MS)) begin
        reg_rdata <= {18'h0, judge_ms_reg};
      end
      for (int i = 0; i < 3; i++) begin
        if (hit(reg_addr, 8'(`OFS_DELAY1 + 4 * i))) begin
          reg_rdata <= {16'h0, delay_reg[i]};
        end
      end
      if (hit(reg_addr, `OFS_STATE)) begin
        reg_rdata <= {24'h0, led_steady_green, alarm_message,
                      alarm_cancel, load_judge, 3'(state_reg), servo_on};
      end
      if (hit(reg_addr, `OFS_IRQ_STAT)) begin
        reg_rdata <= {29'h0, irq_stat_reg};
      end
      if (hit(reg_addr, `OFS_IRQ_MASK)) begin
        reg_rdata <= {29'h0, irq_mask_reg};
      end
      for (int i = 0; i < `TABLE_WORDS; i++) begin
        if (hit(reg_addr, 8'(`OFS_TABLE + 4 * i))) begin
          reg_rdata <= table_reg[i];
        end
      end
    end
  end

  // Table entry of the position being moved to or held
  always_comb begin
    entry.zone_lo   = table_reg[2 * cur_no_reg + 1][15:0];
    entry.zone_hi   = table_reg[2 * cur_no_reg + 1][31:16];
    entry.threshold = table_reg[2 * cur_no_reg][6:0];
    entry.stop_mode = stop_mode_e'(table_reg[2 * cur_no_reg]
                                   [`TBL_MODE_LSB +: 2]);
  end

  assign detect_en  = sel_reg[0];
  assign exempt_sel = sel_reg[1];
  // Thresholds above 100 are treated as 100
  assign over = (entry.threshold != 7'h0) &&
                (motion.cmd_current_pct >
                 ((entry.threshold > `THRESH_MAX) ? `THRESH_MAX
                                                  : entry.threshold));
  assign collision = detect_en && !suppress_reg && (state_reg == SV_MOVING)
                     && tick_ms && (dwell_reg > judge_ms_reg);

  // Movement bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_no_reg      <= '0;
      table_move_reg  <= 1'b0;
      pressing_reg    <= 1'b0;
      suppress_reg    <= 1'b0;
      after_pause_reg <= 1'b0;
      positioned_reg  <= 1'b0;
    end else begin
      if (motion.pause_release) begin
        after_pause_reg <= 1'b1;
      end
      if (motion.move_start && state_reg != SV_FAULT) begin
        cur_no_reg     <= motion.target_no;
        table_move_reg <= motion.from_table;
        pressing_reg   <= motion.pressing;
        // Exempt moves stay exempt for their whole length
        suppress_reg   <= exempt_sel && (after_pause_reg || motion.pause_release
                          || in_zone(motion.current_pos,
                             pos_entry_s'({entry.stop_mode, entry.threshold,
                             table_reg[2 * motion.target_no + 1]})));
        after_pause_reg <= 1'b0;
      end
      if (motion.move_done && state_reg == SV_MOVING) begin
        positioned_reg <= 1'b1;
      end
    end
  end

  // In-zone dwell above threshold, in milliseconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_reg <= 14'h0;
    end else if (state_reg != SV_MOVING || !over ||
                 !in_zone(motion.current_pos, entry)) begin
      dwell_reg <= 14'h0;
    end else if (tick_ms && dwell_reg != 14'h3fff) begin
      dwell_reg <= dwell_reg + 14'h1;
    end
  end

  // Global mode until first positioning, table mode after table moves
  assign mode_sel = (positioned_reg && table_move_reg) ? entry.stop_mode
                                                       : gmode_reg;
  always_comb begin
    case (mode_sel)
      STOP_DELAY1: delay_sel = delay_reg[0];
      STOP_DELAY2: delay_sel = delay_reg[1];
      STOP_DELAY3: delay_sel = delay_reg[2];
      default:     delay_sel = 16'h0;
    endcase
  end

  // A press that touched something holds position, so it never arms
  assign arm = motion.move_done &&
               !(pressing_reg && motion.press_contact);
  assign expire = (mode_sel != STOP_KEEP_ON) &&
                  (sec_reg >= delay_sel);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SV_IDLE: begin
        if (motion.move_start) begin
          state_next = SV_MOVING;
        // Only idle before the first positioning times out; idle after a contacted press holds
        end else if (expire && !positioned_reg) begin
          state_next = SV_AUTO_OFF;
        end
      end
      SV_MOVING: begin
        if (collision && !sel_reg[2]) begin
          state_next = SV_FAULT;
        end else if (motion.move_done) begin
          state_next = arm ? SV_WAIT_OFF : SV_IDLE;
        end
      end
      SV_WAIT_OFF: begin
        if (motion.move_start) begin
          state_next = SV_MOVING;
        end else if (expire) begin
          state_next = SV_AUTO_OFF;
        end
      end
      SV_AUTO_OFF: begin
        if (motion.move_start) begin
          state_next = SV_MOVING;
        end
      end
      SV_FAULT: begin
        if (alarm_clear) begin
          state_next = SV_IDLE;
        end
      end
      default: state_next = SV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Seconds since completion; power-up idle counts from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg <= 16'h0;
    end else if (state_next != state_reg ||
                 (state_reg == SV_IDLE && positioned_reg)) begin
      sec_reg <= 16'h0;
    end else if (tick_s && sec_reg != 16'hffff) begin
      sec_reg <= sec_reg + 16'h1;
    end
  end

  // Alarms stay until software clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_judge    <= 1'b0;
      alarm_cancel  <= 1'b0;
      alarm_message <= 1'b0;
    end else if (collision) begin
      load_judge    <= 1'b1;
      alarm_cancel  <= alarm_cancel  | !sel_reg[2];
      alarm_message <= alarm_message |  sel_reg[2];
    end else if (alarm_clear) begin
      load_judge    <= 1'b0;
      alarm_cancel  <= 1'b0;
      alarm_message <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (state_next == SV_MOVING || state_next == SV_FAULT) begin
      done_reg <= 1'b0;
    end else if (motion.move_done && state_reg == SV_MOVING) begin
      done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on                  <= 1'b1;
      positioning_complete      <= 1'b0;
      completed_position_number <= '0;
      led_steady_green          <= 1'b0;
    end else begin
      servo_on <= !(state_next == SV_AUTO_OFF ||
                    state_next == SV_FAULT);
      led_steady_green <= (state_next == SV_AUTO_OFF);
      if (state_next == SV_AUTO_OFF) begin
        positioning_complete <= cmode_reg && done_reg &&
                                motion.in_position;
      end else if (state_next == SV_MOVING || state_next == SV_FAULT) begin
        // A new command drops completion at once, not a cycle later
        positioning_complete <= 1'b0;
      end else begin
        positioning_complete <= done_reg ||
          (motion.move_done && state_reg == SV_MOVING);
      end
      if (state_next == SV_AUTO_OFF && !cmode_reg) begin
        completed_position_number <= '0;
      end else begin
        completed_position_number <= cur_no_reg;
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <=
        (irq_stat_reg &
         ~((reg_wr && hit(reg_addr, `OFS_IRQ_STAT)) ?
           reg_wdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}})) |
        {motion.move_done && state_reg == SV_MOVING,
         state_next == SV_AUTO_OFF && state_reg != SV_AUTO_OFF,
         collision};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// file: test/servo_guard_check_properties.sv
/*
  Port-level checker of the collision and auto servo-off supervisor.
  Assumes it is bound to servo_guard and sees only that module's ports.
*/
`timescale 1ns/100ps
module servo_guard_check
  import servo_guard_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire motion_in_s           motion,
  input wire logic                 servo_on,
  input wire logic                 load_judge,
  input wire logic                 alarm_cancel,
  input wire logic                 alarm_message,
  input wire logic                 positioning_complete,
  input wire pos_no_t              completed_position_number,
  input wire logic [POS_COUNT-1:0] per_position_done_flag,
  input wire logic                 led_steady_green
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_flag_map: assert property (
    per_position_done_flag == (positioning_complete ?
      8'h01 << completed_position_number : 8'h00))
    else $error("done flags disagree with number");
  a_green_off: assert property (
    led_steady_green |-> !servo_on)
    else $error("green lamp with servo on");
  a_resume_on: assert property (
    led_steady_green && motion.move_start |=> servo_on && !led_steady_green)
    else $error("command did not restore servo");
  a_start_on: assert property (
    motion.move_start && !alarm_cancel |=> servo_on && !positioning_complete)
    else $error("start did not cancel standby");
  a_cancel_off: assert property (
    alarm_cancel && $past(alarm_cancel) |-> !servo_on)
    else $error("servo on under cancel alarm");
  a_msg_keeps: assert property (
    $rose(alarm_message) |-> servo_on)
    else $error("message alarm dropped servo");
  a_load_alarm: assert property (
    alarm_cancel || alarm_message |-> load_judge)
    else $error("alarm without load output");
  a_done_complete: assert property (
    motion.move_done && !motion.press_contact && servo_on &&
    !positioning_complete && !alarm_cancel |=> positioning_complete)
    else $error("completion not shown");
  a_contact_hold: assert property (
    motion.move_done && motion.pressing && motion.press_contact
    |=> servo_on [*8])
    else $error("servo dropped after pressing contact");
  a_off_green: assert property (
    $fell(servo_on) && !alarm_cancel |-> led_steady_green)
    else $error("auto-off without green lamp");
endmodule

bind servo_guard servo_guard_check servo_guard_check_i (
  .clk, .rst_n, .motion, .servo_on, .load_judge, .alarm_cancel,
  .alarm_message, .positioning_complete, .completed_position_number,
  .per_position_done_flag, .led_steady_green);

// file: test/motion_host.sv
/*
  Model of the fieldbus host issuing positioning commands.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/100ps
module motion_host
  import servo_guard_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [6:0]  cur_pct,
  input  wire logic [15:0] pos,
  input  wire logic        in_pos,
  output motion_in_s       motion
);
  logic    start = 1'b0;
  logic    pause = 1'b0;
  logic    done = 1'b0;
  logic    contact = 1'b1;
  logic    tbl = 1'b0;
  logic    press = 1'b0;
  pos_no_t tgt = 3'h0;

  assign motion = {start, tgt, tbl, press, pause, done, contact, in_pos,
                   cur_pct, pos};

  task automatic go(input pos_no_t t, input logic tb, input logic pr);
    @(posedge clk);
    start <= 1'b1;
    tgt   <= t;
    tbl   <= tb;
    press <= pr;
    @(posedge clk);
    start <= 1'b0;
  endtask

  // Contact is only meaningful with done, so it shows junk otherwise
  task automatic stop(input logic ct);
    @(posedge clk);
    done    <= 1'b1;
    contact <= ct;
    @(posedge clk);
    done    <= 1'b0;
    contact <= ~ct;
  endtask

  task automatic pause_pulse();
    @(posedge clk);
    pause <= 1'b1;
    @(posedge clk);
    pause <= 1'b0;
  endtask
endmodule

// file: test/servo_guard_test.sv
/*
  Self-checking bench of the collision and auto servo-off supervisor.
  Assumes the package, the host model and the bound checker.
*/
`timescale 1ns/100ps
`include "servo_guard_params.svh"
module servo_guard_test
  import servo_guard_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  cur_pct = 7'd80;
  logic [15:0] pos = 16'h0000;
  logic        in_pos = 1'b0;
  logic [31:0] reg_rdata;
  motion_in_s  motion;
  logic        servo_on, load_judge, alarm_cancel, alarm_message;
  logic        positioning_complete, led_steady_green, irq;
  pos_no_t     number;
  logic [7:0]  flags;
  int          n_errors = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  // Short ms tick keeps one second at 10000 cycles
  servo_guard #(.MS_CYCLES(10)) servo_guard_i (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .motion, .servo_on, .load_judge, .alarm_cancel, .alarm_message,
    .positioning_complete, .completed_position_number(number),
    .per_position_done_flag(flags), .led_steady_green, .irq);
  motion_host motion_host_i (.clk, .cur_pct, .pos, .in_pos, .motion);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic wait_off(input int lim);
    for (int i = 0; i < lim && servo_on !== 1'b0; i++) cyc(1);
    chk(servo_on, 32'h0);
  endtask

  task automatic move(input pos_no_t t, input logic tb);
    motion_host_i.go(t, tb, 1'b0);
    motion_host_i.stop(1'b0);
    #1;
  endtask

  task automatic t_regs();
    chk(servo_on, 32'h1);
    rd_chk(`OFS_JUDGE_MS, 32'd255);
    wr(`OFS_JUDGE_MS, 32'd10000);
    rd_chk(`OFS_JUDGE_MS, 32'd9999);
    rd_chk(8'h30, 32'h0);
    rd_chk(`OFS_DELAY1, 32'h0);
    wr(`OFS_DELAY3, 32'd2);
    rd_chk(`OFS_DELAY3, 32'd2);
    rd_chk(`OFS_DELAY2, 32'h0);
  endtask

  task automatic t_global();
    wr(`OFS_CFG, 32'h10);
    rd_chk(`OFS_CFG, 32'h10);
    wait_off(100);
    chk(led_steady_green, 32'h1);
    rd_chk(`OFS_STATE, 32'h86);
    motion_host_i.go(3'd0, 1'b0, 1'b0);
    #1;
    chk(servo_on, 32'h1);
    chk(led_steady_green, 32'h0);
    motion_host_i.stop(1'b0);
    #1;
    chk(positioning_complete, 32'h1);
    wait_off(100);
  endtask

  task automatic t_table();
    wr(`OFS_TABLE + 8'h08, 32'h00030000);
    wr(`OFS_TABLE + 8'h10, 32'h00020000);
    wr(`OFS_TABLE + 8'h18, 32'h00000000);
    move(3'd3, 1'b1);
    cyc(300);
    chk(servo_on, 32'h1);
    chk(flags, 32'h08);
    wr(`OFS_CFG, 32'h0);
    move(3'd1, 1'b1);
    cyc(9000);
    chk(servo_on, 32'h1);
    wait_off(12000);
    chk(positioning_complete, 32'h0);
    chk(number, 32'h0);
    chk(flags, 32'h0);
    wr(`OFS_CFG, 32'h100);
    in_pos <= 1'b1;
    move(3'd2, 1'b1);
    wait_off(200);
    chk(positioning_complete, 32'h1);
    chk(number, 32'h2);
    chk(flags, 32'h04);
    in_pos <= 1'b0;
  endtask

  task automatic t_press();
    wr(`OFS_CFG, 32'h10);
    motion_host_i.go(3'd0, 1'b0, 1'b1);
    motion_host_i.stop(1'b1);
    cyc(200);
    chk(servo_on, 32'h1);
    motion_host_i.go(3'd0, 1'b0, 1'b1);
    motion_host_i.stop(1'b0);
    wait_off(100);
  endtask

  // Zone is 100..200 and current 80 percent for position 5
  task automatic collide(input logic [2:0] sel, input logic [15:0] p0,
                         input logic [15:0] p1, input logic pz,
                         input logic [6:0] thr, input logic hit);
    wr(`OFS_CFG, {29'h0, sel});
    wr(`OFS_TABLE + 8'h28, {25'h0, thr});
    pos <= p0;
    if (pz) motion_host_i.pause_pulse();
    motion_host_i.go(3'd5, 1'b1, 1'b0);
    pos <= p1;
    cyc(100);
    chk(load_judge, hit);
    chk(alarm_cancel, hit & ~sel[2]);
    chk(alarm_message, hit & sel[2]);
    chk(servo_on, {31'h0, ~(hit & ~sel[2])});
    pos <= 16'd0;
    motion_host_i.stop(1'b0);
    wr(`OFS_CMD, 32'h1);
    cyc(1);
    chk(load_judge, 32'h0);
    chk(servo_on, 32'h1);
  endtask

  task automatic t_collisions();
    wr(`OFS_JUDGE_MS, 32'd2);
    wr(`OFS_TABLE + 8'h2c, 32'h00c80064);
    for (int s = 0; s < 8; s++)
      collide(s[2:0], 16'd0, 16'd150, 1'b0, 7'd50, s[0]);
    collide(3'd3, 16'd150, 16'd150, 1'b0, 7'd50, 1'b0);
    collide(3'd7, 16'd0, 16'd150, 1'b1, 7'd50, 1'b0);
    collide(3'd1, 16'd150, 16'd150, 1'b1, 7'd50, 1'b1);
    collide(3'd1, 16'd0, 16'd150, 1'b0, 7'd0, 1'b0);
    collide(3'd1, 16'd0, 16'd150, 1'b0, 7'd80, 1'b0);
    collide(3'd1, 16'd0, 16'd150, 1'b0, 7'd79, 1'b1);
    collide(3'd1, 16'd0, 16'd201, 1'b0, 7'd50, 1'b0);
    collide(3'd1, 16'd0, 16'd200, 1'b0, 7'd50, 1'b1);
    // Current below the threshold must not count as a collision
    cur_pct <= 7'd40;
    collide(3'd1, 16'd0, 16'd150, 1'b0, 7'd50, 1'b0);
    cur_pct <= 7'd80;
  endtask

  task automatic t_irq();
    wr(`OFS_IRQ_MASK, 32'h7);
    wr(`OFS_IRQ_STAT, 32'h7);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
    // A mask bit set lets its status bit through to the interrupt
    wr(`OFS_IRQ_MASK, 32'h4);
    move(3'd0, 1'b0);
    chk(irq, 32'h1);
    rd_chk(`OFS_IRQ_STAT, 32'h4);
    wr(`OFS_IRQ_MASK, 32'h3);
    cyc(1);
    chk(irq, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h4);
    wr(`OFS_IRQ_STAT, 32'h4);
    cyc(1);
    chk(irq, 32'h0);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_global();
    t_table();
    t_press();
    t_collisions();
    t_irq();
    report_and_stop();
  end

  // About four times the expected run, dominated by the two-second delay
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule
